/* rtl/pfb_ctrl.sv */
// host-side controller for an asynchronous parallel nor flash bus
// assumes a plain register port on clk and a flash wired straight to the pins
`timescale 1ns/1ps
module pfb_ctrl
   import pfb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [FLASH_ADDR_W-1:0] flash_addr,
   output logic chip_en_n,
   output logic out_en_n,
   output logic wr_en_n,
   output logic flash_reset_n,
   output logic word_mode,
   output logic protect_accel_pin,
   output logic accel_program_voltage,
   input wire logic [DATA_W-1:0] data_lines_i,
   output logic [DATA_W-1:0] data_lines_o,
   output logic [DATA_W-1:0] data_lines_oe,
   input wire logic ready_busy_n
);
   pfb_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CTRL_W-1:0] ctrl_q;
   logic [22:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] rdata_q;
   logic aborted_q;
   logic [SEQ_AW-1:0] seq_idx_q;
   logic seq_final_q;
   logic in_prog_q;
   logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
   logic rb_s1_q, rb_s2_q;
   logic [22:0] cyc_addr_q;
   logic [DATA_W-1:0] cyc_data_q;

   // byte mode address carries A-1 on data line 15
   function automatic logic [FLASH_ADDR_W-1:0] pin_addr(input logic [22:0] a, input logic wm);
      pin_addr = wm ? a[FLASH_ADDR_W-1:0] : a[22:1];
   endfunction : pin_addr

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction : cyc

   wire idle = (state_q == PFB_IDLE);
   wire wr_ctrl = reg_wr && idle && (reg_addr == REG_CTRL);
   wire wr_addr = reg_wr && idle && (reg_addr == REG_ADDR);
   wire wr_wdata = reg_wr && idle && (reg_addr == REG_WDATA);
   wire wr_go = reg_wr && idle && (reg_addr == REG_GO);
   wire wr_status = reg_wr && (reg_addr == REG_STATUS);
   wire wr_seq = reg_wr && idle && ((reg_addr & REG_SEQ_MASK) == REG_SEQ_BASE);
   wire [2:0] go_code = reg_wdata[2:0];
   wire wm = ctrl_q[CTRL_WORD_MODE];
   // high voltage forces the short sequence as well
   wire bypass_on = ctrl_q[CTRL_BYPASS] | ctrl_q[CTRL_ACCEL];
   wire cnt_done = (cnt_q == '0);
   wire mem_rd = (state_q == PFB_FETCH);
   wire [31:0] mem_q;
   wire last_prefix = (seq_idx_q == SEQ_LAST);
   wire rb_ready = rb_s2_q;
   wire reset_hit_busy = wr_go && (go_code == GO_RESET) && !rb_ready;
   wire [DATA_W-1:0] cap_data = wm ? dq_s2_q : {8'h00, dq_s2_q[7:0]};
   wire wr_high_end = (state_q == PFB_WR_HIGH) && cnt_done && in_prog_q && !seq_final_q;
   // pins load the next cycle's address and data with the strobes, so the flash latches settled values
   // prefix cycles stay in the bank of the target address
   wire [22:0] cyc_addr_d = wr_go ? addr_q :
      (state_q == PFB_LOAD) ? {addr_q[22:16], mem_q[31:16]} :
      (wr_high_end && last_prefix) ? addr_q : cyc_addr_q;
   wire [DATA_W-1:0] cyc_data_d = wr_go ? wdata_q :
      (state_q == PFB_LOAD) ? mem_q[15:0] :
      (wr_high_end && last_prefix) ? wdata_q : cyc_data_q;
   wire [FLASH_ADDR_W-1:0] cyc_pin_addr = pin_addr(cyc_addr_d, wm);
   wire [DATA_W-1:0] wr_do = wm ? cyc_data_d : {cyc_addr_d[0], 7'h00, cyc_data_d[7:0]};
   wire [DATA_W-1:0] pin_do_d = (state_d == PFB_WR_LOW) ? wr_do :
      (state_d == PFB_READ && !wm) ? {cyc_addr_d[0], 15'h0000} : 16'h0000;
   wire [DATA_W-1:0] pin_oe_d = (state_d == PFB_WR_LOW) ? (wm ? 16'hFFFF : 16'h80FF) :
      (state_d == PFB_READ && !wm) ? 16'h8000 : 16'h0000;

   pfb_seq_mem #(
      .DEPTH(SEQ_DEPTH),
      .AW(SEQ_AW),
      .W(32)
   ) u_seq (
      .clk(clk),
      .rst(rst),
      .wr_en(wr_seq),
      .wr_addr(reg_addr[SEQ_AW+1:2]),
      .wr_data(reg_wdata),
      .rd_en(mem_rd),
      .rd_addr(seq_idx_q),
      .rd_data(mem_q)
   );

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
      case (state_q)
         PFB_IDLE: begin
            if (wr_go) begin
               case (go_code)
                  GO_READ: begin
                     state_d = PFB_READ;
                     cnt_d = cyc(ADDR_ACCESS_CYC + SYNC_STAGES);
                  end
                  GO_WRITE: begin
                     state_d = PFB_WR_LOW;
                     cnt_d = cyc(WRITE_PULSE_CYC);
                  end
                  GO_PROGRAM: state_d = PFB_FETCH;
                  GO_RESET: begin
                     state_d = PFB_RST_LOW;
                     cnt_d = cyc(RESET_PULSE_MIN_CYC);
                  end
                  default: state_d = PFB_IDLE;
               endcase
            end
         end
         PFB_READ: if (cnt_done) state_d = PFB_READ_END;
         PFB_READ_END: state_d = PFB_IDLE;
         PFB_FETCH: state_d = PFB_LOAD;
         PFB_LOAD: begin
            state_d = PFB_WR_LOW;
            cnt_d = cyc(WRITE_PULSE_CYC);
         end
         PFB_WR_LOW: begin
            if (cnt_done) begin
               state_d = PFB_WR_HIGH;
               cnt_d = cyc(WRITE_HIGH_CYC);
            end
         end
         PFB_WR_HIGH: begin
            if (cnt_done) begin
               if (!in_prog_q || seq_final_q) begin
                  state_d = PFB_IDLE;
               end else if (last_prefix) begin
                  state_d = PFB_WR_LOW;
                  cnt_d = cyc(WRITE_PULSE_CYC);
               end else begin
                  state_d = PFB_FETCH;
               end
            end
         end
         PFB_RST_LOW: begin
            if (cnt_done) begin
               state_d = PFB_RST_WAIT;
               cnt_d = cyc(RESET_TO_READ_CYC);
            end
         end
         PFB_RST_WAIT: if (cnt_done && rb_ready) state_d = PFB_IDLE;
         default: state_d = PFB_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= PFB_RST_LOW;
         cnt_q <= cyc(RESET_PULSE_MIN_CYC);
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // pin inputs pass two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {dq_s2_q, dq_s1_q, rb_s2_q, rb_s1_q} <= '0;
      end else begin
         {dq_s2_q, dq_s1_q} <= {dq_s1_q, data_lines_i};
         {rb_s2_q, rb_s1_q} <= {rb_s1_q, ready_busy_n};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         addr_q <= '0;
         wdata_q <= '0;
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata[CTRL_W-1:0];
         if (wr_addr) addr_q <= reg_wdata[22:0];
         if (wr_wdata) wdata_q <= reg_wdata[DATA_W-1:0];
      end
   end

   // current bus cycle: a table prefix or the final data cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_prog_q <= 1'b0;
         seq_idx_q <= '0;
         seq_final_q <= 1'b0;
         cyc_addr_q <= '0;
         cyc_data_q <= '0;
      end else begin
         cyc_addr_q <= cyc_addr_d;
         cyc_data_q <= cyc_data_d;
         if (wr_go) begin
            in_prog_q <= (go_code == GO_PROGRAM);
            seq_idx_q <= bypass_on ? SEQ_FIRST_BYPASS : SEQ_FIRST_NORMAL;
            seq_final_q <= 1'b0;
         end else if (wr_high_end) begin
            if (last_prefix) seq_final_q <= 1'b1;
            else seq_idx_q <= seq_idx_q + SEQ_AW'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
         aborted_q <= 1'b0;
      end else begin
         if (state_q == PFB_READ && cnt_done) rdata_q <= cap_data;
         // a new abort wins over a clear in the same cycle
         if (reset_hit_busy) aborted_q <= 1'b1;
         else if (wr_status && reg_wdata[STAT_ABORTED]) aborted_q <= 1'b0;
      end
   end

   // pins; chip enable drops only for an active cycle, so idle is standby
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flash_addr <= '0;
         {chip_en_n, out_en_n, wr_en_n} <= 3'h7;
         flash_reset_n <= 1'b0;
         word_mode <= 1'b1;
         protect_accel_pin <= 1'b0;
         accel_program_voltage <= 1'b0;
         data_lines_o <= '0;
         data_lines_oe <= '0;
      end else begin
         // address held between cycles keeps the flash in sleep, reads stay latched
         flash_addr <= cyc_pin_addr;
         word_mode <= wm;
         protect_accel_pin <= ctrl_q[CTRL_WP_HIGH];
         // high voltage only while a program sequence runs
         accel_program_voltage <= ctrl_q[CTRL_ACCEL] && in_prog_q && !idle && flash_reset_n;
         flash_reset_n <= !(state_d == PFB_RST_LOW);
         chip_en_n <= !(state_d == PFB_READ || state_d == PFB_WR_LOW);
         out_en_n <= !(state_d == PFB_READ);
         wr_en_n <= !(state_d == PFB_WR_LOW);
         data_lines_o <= pin_do_d;
         data_lines_oe <= pin_oe_d;
      end
   end

   wire [31:0] status_word = {29'h0, aborted_q, rb_ready, !idle};
   wire [31:0] rd_mux =
      (reg_addr == REG_CTRL) ? {28'h0, ctrl_q} :
      (reg_addr == REG_ADDR) ? {9'h000, addr_q} :
      (reg_addr == REG_WDATA) ? {16'h0000, wdata_q} :
      (reg_addr == REG_STATUS) ? status_word :
      (reg_addr == REG_RDATA) ? {16'h0000, rdata_q} : 32'h0000_0000;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end
endmodule : pfb_ctrl

/* rtl/pfb_pkg.sv */
// constants and types for the parallel flash bus controller
// assumes a 100 MHz clock; timing figures below are given in ns and rounded up to cycles of that clock
package pfb_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // flash timing figures in ns; plain defaults, set for the speed grade used
   localparam int ADDR_ACCESS_TIME_NS = 70;
   localparam int WRITE_PULSE_NS = 35;
   localparam int WRITE_HIGH_NS = 20;
   localparam int RESET_PULSE_MIN_NS = 500;
   localparam int RESET_TO_READ_TIME_NS = 50;
   // least times round up
   localparam int ADDR_ACCESS_CYC = (ADDR_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_TO_READ_CYC = (RESET_TO_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   localparam int CNT_W = 16;

   localparam int FLASH_ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int REG_ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_GO = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA = 8'h14;
   localparam logic [7:0] REG_SEQ_BASE = 8'h20;
   localparam logic [7:0] REG_SEQ_MASK = 8'hF0;

   // control field positions
   localparam int CTRL_WORD_MODE = 0;
   localparam int CTRL_WP_HIGH = 1;
   localparam int CTRL_BYPASS = 2;
   localparam int CTRL_ACCEL = 3;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RESET = 4'h1;

   // status field positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_READY = 1;
   localparam int STAT_ABORTED = 2;

   // go codes
   localparam logic [2:0] GO_READ = 3'h1;
   localparam logic [2:0] GO_WRITE = 3'h2;
   localparam logic [2:0] GO_PROGRAM = 3'h3;
   localparam logic [2:0] GO_RESET = 3'h4;

   // command sequence table: three prefix cycles, one in bypass, then the data cycle
   localparam int SEQ_DEPTH = 4;
   localparam int SEQ_AW = 2;
   localparam logic [1:0] SEQ_FIRST_NORMAL = 2'h0;
   localparam logic [1:0] SEQ_FIRST_BYPASS = 2'h2;
   localparam logic [1:0] SEQ_LAST = 2'h2;

   typedef enum logic [3:0] {
      PFB_IDLE, PFB_READ, PFB_READ_END, PFB_FETCH, PFB_LOAD,
      PFB_WR_LOW, PFB_WR_HIGH, PFB_RST_LOW, PFB_RST_WAIT
   } pfb_state_t;
endpackage : pfb_pkg

/* rtl/pfb_seq_mem.sv */
// small table of command-prefix cycles, {address low half, data}
// assumes one writer and one reader on the controller clock
`timescale 1ns/1ps
module pfb_seq_mem #(
   parameter int DEPTH = 4,
   parameter int AW = 2,
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem_q [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule : pfb_seq_mem

/* bench/pfb_monitor.sv */
// checker for the flash pin timing of pfb_ctrl
// assumes it is bound to pfb_ctrl and sees only its ports
`timescale 1ns/1ps
module pfb_monitor
   import pfb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic flash_reset_n,
   input wire logic word_mode,
   input wire logic accel_program_voltage,
   input wire logic [DATA_W-1:0] data_lines_oe
);
   logic [CNT_W-1:0] low_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) low_q <= '0;
      else if (flash_reset_n) low_q <= '0;
      else if (low_q != 16'hFFFF) low_q <= low_q + 16'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_low; (!out_en_n && !chip_en_n)[*7]; endsequence
   sequence rd_end; (!out_en_n)[*2] ##1 out_en_n; endsequence
   sequence wr_low; (!wr_en_n && !chip_en_n)[*4]; endsequence
   sequence wr_gap; wr_en_n[*2]; endsequence
   read_strobe_a: assert property (!out_en_n |-> !chip_en_n && wr_en_n)
      else $error("read strobes wrong");
   write_strobe_a: assert property (!wr_en_n |-> !chip_en_n && out_en_n)
      else $error("write strobes wrong");
   read_length_a: assert property ($fell(out_en_n) |-> rd_low ##1 rd_end)
      else $error("read cycle length wrong");
   write_pulse_a: assert property ($fell(wr_en_n) |-> wr_low ##1 wr_gap)
      else $error("write pulse length wrong");
   bus_release_a: assert property (!out_en_n |-> data_lines_oe[14:0] == 15'h0)
      else $error("host drives during read");
   byte_float_a: assert property (!word_mode |-> data_lines_oe[14:8] == 7'h0)
      else $error("upper lines driven in byte mode");
   accel_use_a: assert property (accel_program_voltage |-> out_en_n)
      else $error("high voltage during read");
   reset_pulse_a: assert property ($rose(flash_reset_n) |-> low_q >= RESET_PULSE_MIN_CYC)
      else $error("flash reset pulse short");
   reset_quiet_a: assert property (!flash_reset_n |-> chip_en_n && data_lines_oe == 16'h0)
      else $error("activity during flash reset");
   reset_read_a: assert property ($rose(flash_reset_n) |-> chip_en_n[*5])
      else $error("access too soon after reset");
   standby_a: assert property (chip_en_n |-> out_en_n && wr_en_n)
      else $error("strobe while deselected");
endmodule : pfb_monitor

bind pfb_ctrl pfb_monitor pfb_monitor_i (.clk(clk), .rst(rst), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
   .wr_en_n(wr_en_n), .flash_reset_n(flash_reset_n), .word_mode(word_mode),
   .accel_program_voltage(accel_program_voltage), .data_lines_oe(data_lines_oe));

/* bench/pfb_flash_model.sv */
// behavioural nor flash: array, program arming, protection, busy and reset
// assumes the bench resolves the data bus; only the low 64k words are stored
`timescale 1ns/1ps
module pfb_flash_model
   import pfb_pkg::*;
(
   input wire logic clk,
   input wire logic [FLASH_ADDR_W-1:0] flash_addr,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic flash_reset_n,
   input wire logic word_mode,
   input wire logic protect_accel_pin,
   input wire logic accel_program_voltage,
   input wire logic [DATA_W-1:0] bus,
   output logic [DATA_W-1:0] flash_o,
   output logic ready_busy_n
);
   logic [15:0] mem [0:65535];
   logic [15:0] noise_q = 16'hA5A5;
   logic [FLASH_ADDR_W-1:0] a_q = '0;
   logic [15:0] d_q = '0;
   logic we_q = 1'b1;
   logic armed_q = 1'b0;
   logic pend_q = 1'b0;
   logic [15:0] pa_q = '0;
   logic [15:0] pd_q = '0;
   int busy_q = 0;
   wire rd_on = !chip_en_n && !out_en_n && wr_en_n && flash_reset_n;
   wire [15:0] word = mem[flash_addr[15:0]];
   wire [15:0] val = word_mode ? word : {8'h0, bus[15] ? word[15:8] : word[7:0]};
   // released lines toggle so a stale value can never pass as data
   assign flash_o = rd_on ? val : noise_q;
   assign ready_busy_n = (busy_q == 0);
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
   end
   always @(posedge clk) begin
      noise_q <= ~noise_q;
      we_q <= wr_en_n;
      if (busy_q > 0) busy_q <= busy_q - 1;
      // a program lands only when its busy time runs out, so a reset in between loses it
      if (busy_q == 1 && pend_q && flash_reset_n) mem[pa_q] <= pd_q;
      if (busy_q == 1) pend_q <= 1'b0;
      if (!flash_reset_n) begin
         armed_q <= 1'b0;
         pend_q <= 1'b0;
      end else if (!wr_en_n && !chip_en_n && out_en_n) begin
         a_q <= flash_addr;
         d_q <= bus;
      end else if (!we_q && wr_en_n) begin
         if (armed_q) begin
            pend_q <= accel_program_voltage || protect_accel_pin || a_q >= 22'h002000;
            pa_q <= a_q[15:0];
            pd_q <= d_q;
            busy_q <= 200;
            armed_q <= 1'b0;
         end else if (d_q[7:0] == 8'hA0) armed_q <= 1'b1;
      end
   end
endmodule : pfb_flash_model

/* bench/pfb_ctrl_tb.sv */
// self-checking bench for pfb_ctrl against the flash model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module pfb_ctrl_tb;
   import pfb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [REG_ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   wire [31:0] reg_rdata;
   wire [FLASH_ADDR_W-1:0] flash_addr;
   wire chip_en_n, out_en_n, wr_en_n, flash_reset_n, word_mode, protect_accel_pin, accel_program_voltage, ready_busy_n;
   wire [DATA_W-1:0] dq_o, dq_oe, flash_o, bus;
   int err_total = 0;
   int checks = 0;
   int nwr = 0;
   logic we_q = 1'b1;
   logic acc_seen = 1'b0;
   logic [31:0] v;
   always #5 clk = ~clk;
   assign bus = (dq_oe & dq_o) | (~dq_oe & flash_o);
   always @(posedge clk) begin
      we_q <= wr_en_n;
      if (we_q && !wr_en_n) nwr++;
      if (accel_program_voltage) acc_seen <= 1'b1;
   end
   pfb_ctrl pfb_ctrl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
      .wr_en_n(wr_en_n), .flash_reset_n(flash_reset_n), .word_mode(word_mode), .protect_accel_pin(protect_accel_pin),
      .accel_program_voltage(accel_program_voltage), .data_lines_i(bus), .data_lines_o(dq_o),
      .data_lines_oe(dq_oe), .ready_busy_n(ready_busy_n));
   pfb_flash_model pfb_flash_model_i (.clk(clk), .flash_addr(flash_addr), .chip_en_n(chip_en_n),
      .out_en_n(out_en_n), .wr_en_n(wr_en_n), .flash_reset_n(flash_reset_n), .word_mode(word_mode),
      .protect_accel_pin(protect_accel_pin), .accel_program_voltage(accel_program_voltage), .bus(bus),
      .flash_o(flash_o), .ready_busy_n(ready_busy_n));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // full also waits for the flash ready line, as a new command needs it
   task automatic wait_idle(input logic full);
      logic [31:0] s;
      for (int i = 0; i < 3000; i++) begin
         rd(REG_STATUS, s);
         if (s[0] === 1'b0 && (!full || s[1] === 1'b1)) return;
      end
      chk(s, 32'h2, "wait idle timed out");
   endtask : wait_idle
   task automatic prog(input logic [3:0] c, input logic [22:0] a, input logic [15:0] d, input logic [31:0] n);
      int n0;
      wait_idle(1'b1);
      wr(REG_CTRL, {28'h0, c});
      wr(REG_ADDR, {9'h0, a});
      wr(REG_WDATA, {16'h0, d});
      n0 = nwr;
      wr(REG_GO, 32'h3);
      wait_idle(1'b0);
      chk(32'(nwr - n0), n, "write cycle count");
   endtask : prog
   task automatic rdf(input logic [22:0] a, input logic [31:0] exp);
      logic [31:0] d;
      wait_idle(1'b1);
      wr(REG_ADDR, {9'h0, a});
      wr(REG_GO, 32'h1);
      wait_idle(1'b0);
      rd(REG_RDATA, d);
      chk(d, exp, "read data");
   endtask : rdf
   task automatic one(input logic [22:0] a, input logic [15:0] d);
      int n0;
      wait_idle(1'b1);
      wr(REG_ADDR, {9'h0, a});
      wr(REG_WDATA, {16'h0, d});
      n0 = nwr;
      wr(REG_GO, 32'h2);
      wait_idle(1'b0);
      chk(32'(nwr - n0), 32'h1, "single write count");
   endtask : one
   initial begin
      #300_000;
      err_total++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_idle(1'b1);
      rd(REG_STATUS, v);
      chk(v, 32'h2, "status after reset");
      rd(REG_CTRL, v);
      chk(v, 32'h1, "control after reset");
      rd(8'h3C, v);
      chk(v, 32'h0, "unmapped read");
      rdf(23'h1234, 32'hFFFF);
      wr(8'h20, 32'h0555_00AA);
      wr(8'h24, 32'h02AA_0055);
      wr(8'h28, 32'h0555_00A0);
      prog(4'h3, 23'h1234, 16'hBEEF, 32'h4);
      rdf(23'h1234, 32'hBEEF);
      prog(4'h7, 23'h1235, 16'h1357, 32'h2);
      rdf(23'h1235, 32'h1357);
      prog(4'h1, 23'h0010, 16'h0000, 32'h4);
      rdf(23'h0010, 32'hFFFF);
      chk(32'(acc_seen), 32'h0, "high voltage without accel");
      prog(4'h9, 23'h0010, 16'h2468, 32'h2);
      chk(32'(acc_seen), 32'h1, "high voltage in accel");
      rdf(23'h0010, 32'h2468);
      wr(REG_CTRL, 32'h2);
      rdf(23'h2469, 32'hBE);
      rdf(23'h2468, 32'hEF);
      prog(4'h3, 23'h1300, 16'h0F0F, 32'h4);
      wr(REG_GO, 32'h4);
      wait_idle(1'b1);
      rd(REG_STATUS, v);
      chk(v, 32'h6, "abort flagged");
      wr(REG_STATUS, 32'h4);
      rd(REG_STATUS, v);
      chk(v, 32'h2, "abort cleared");
      rdf(23'h1300, 32'hFFFF);
      prog(4'h3, 23'h1300, 16'h0F0F, 32'h4);
      rdf(23'h1300, 32'h0F0F);
      one(23'h0555, 16'h00A0);
      one(23'h1400, 16'h1111);
      rdf(23'h1400, 32'h1111);
      complete_run();
   end
endmodule : pfb_ctrl_tb
